// ===== src/lva_pkg.sv
// Purpose: Shared constants for the LED engine variable datapath
// Assumes: Three engines, 8-bit variables, one clock
// Notes: Operation codes are local to this block
package lva_pkg;
   localparam int NUM_ENG = 3;
   localparam int VAR_W = 8;
   localparam int SEL_W = 2;
   localparam int ENG_W = 2;
   localparam int OP_W = 3;
   localparam logic [VAR_W-1:0] VAR_RESET = 8'h00;
   // Operation codes on the op port
   localparam logic [OP_W-1:0] OP_NONE = 3'h0;
   localparam logic [OP_W-1:0] OP_LOAD_IMM = 3'h1;
   localparam logic [OP_W-1:0] OP_ADD_IMM = 3'h2;
   localparam logic [OP_W-1:0] OP_ADD_VAR = 3'h3;
   localparam logic [OP_W-1:0] OP_SUB_IMM = 3'h4;
   localparam logic [OP_W-1:0] OP_SUB_VAR = 3'h5;
   // Variable selector codes
   localparam logic [SEL_W-1:0] SEL_A = 2'h0;
   localparam logic [SEL_W-1:0] SEL_B = 2'h1;
   localparam logic [SEL_W-1:0] SEL_C = 2'h2;
   localparam logic [SEL_W-1:0] SEL_EXT = 2'h3;
endpackage : lva_pkg

// ===== src/lva_local_vars.sv
// Purpose: Private A and B variables of one program engine
// Assumes: Write strobe already qualified by engine number
// Notes: One instance per engine
`timescale 1ns/10ps
module lva_local_vars
   import lva_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wr_a,
   input wire logic wr_b,
   input wire logic [lva_pkg::VAR_W-1:0] wr_data,
   output logic [lva_pkg::VAR_W-1:0] var_a,
   output logic [lva_pkg::VAR_W-1:0] var_b
);
   logic [VAR_W-1:0] a_ff;
   logic [VAR_W-1:0] b_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_ff <= VAR_RESET;
      end else if (wr_a) begin
         a_ff <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         b_ff <= VAR_RESET;
      end else if (wr_b) begin
         b_ff <= wr_data;
      end
   end

   assign var_a = a_ff;
   assign var_b = b_ff;
endmodule : lva_local_vars

// ===== src/lva_operand_mux.sv
// Purpose: Selects one source operand from a 2-bit code
// Assumes: External value is supplied by the register file
// Notes: Used twice, for operand one and operand two
`timescale 1ns/10ps
module lva_operand_mux
   import lva_pkg::*;
(
   input wire logic [lva_pkg::SEL_W-1:0] sel,
   input wire logic [lva_pkg::VAR_W-1:0] loc_a,
   input wire logic [lva_pkg::VAR_W-1:0] loc_b,
   input wire logic [lva_pkg::VAR_W-1:0] glob_c,
   input wire logic [lva_pkg::VAR_W-1:0] ext_val,
   output logic [lva_pkg::VAR_W-1:0] operand
);
   always_comb begin
      case (sel)
         SEL_A: operand = loc_a;
         SEL_B: operand = loc_b;
         SEL_C: operand = glob_c;
         default: operand = ext_val;
      endcase
   end
endmodule : lva_operand_mux

// ===== src/lva_var_alu.sv
// Purpose: Variable store and arithmetic for three LED program engines
// Assumes: Sequencer issues at most one operation per cycle
// Notes: Results wrap modulo 256; no carry or borrow flag exists
`timescale 1ns/10ps
// Contract
// - Each engine keeps private variables A and B unseen by others.
// - One global variable C is shared by all three engines.
// - Load-immediate overwrites target A, B or C with constant.
// - Add-immediate adds constant to target and writes it back.
// - Add-variables sums two selected operands into target.
// - Add-variables sum wraps modulo 256.
// - Subtract-immediate deducts constant from target, writes back.
// - Subtract-variables stores operand one minus operand two.
// - Subtract-variables difference wraps modulo 256.
// - Source code 0 A, 1 B, 2 global, 3 external value.
module lva_var_alu
   import lva_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic op_valid,
   input wire logic [lva_pkg::OP_W-1:0] op_code,
   input wire logic [lva_pkg::ENG_W-1:0] eng_sel,
   input wire logic [lva_pkg::SEL_W-1:0] target_sel,
   input wire logic [lva_pkg::SEL_W-1:0] src1_sel,
   input wire logic [lva_pkg::SEL_W-1:0] src2_sel,
   input wire logic [lva_pkg::VAR_W-1:0] imm_val,
   input wire logic [lva_pkg::VAR_W-1:0] ext_val,
   output logic [lva_pkg::VAR_W-1:0] result_ff,
   output logic result_valid_ff,
   output logic [lva_pkg::VAR_W-1:0] op1_val,
   output logic [lva_pkg::VAR_W-1:0] op2_val,
   output logic [lva_pkg::VAR_W*lva_pkg::NUM_ENG-1:0] var_a_all,
   output logic [lva_pkg::VAR_W*lva_pkg::NUM_ENG-1:0] var_b_all,
   output logic [lva_pkg::VAR_W-1:0] var_c
);
   import lva_pkg::*;

   logic [VAR_W-1:0] c_ff;
   logic [VAR_W-1:0] loc_a [NUM_ENG];
   logic [VAR_W-1:0] loc_b [NUM_ENG];
   logic [VAR_W-1:0] sel_a;
   logic [VAR_W-1:0] sel_b;
   logic [VAR_W-1:0] tgt_val;
   logic [VAR_W-1:0] nxt_result;
   logic do_write;
   logic eng_ok;
   logic [NUM_ENG-1:0] wr_a;
   logic [NUM_ENG-1:0] wr_b;
   logic wr_c;

   genvar g;
   generate
      for (g = 0; g < NUM_ENG; g++) begin : g_eng
         // Private store per engine; no other engine can address it
         lva_local_vars u_loc (
            .clk(clk),
            .rstn(rstn),
            .wr_a(wr_a[g]),
            .wr_b(wr_b[g]),
            .wr_data(nxt_result),
            .var_a(loc_a[g]),
            .var_b(loc_b[g])
         );
         assign var_a_all[g*VAR_W +: VAR_W] = loc_a[g];
         assign var_b_all[g*VAR_W +: VAR_W] = loc_b[g];
      end
   endgenerate

   // Engine number out of range selects engine 0 data and writes only result_ff
   assign eng_ok = (eng_sel < ENG_W'(NUM_ENG));

   always_comb begin
      sel_a = loc_a[0];
      sel_b = loc_b[0];
      if (eng_sel == 2'h1) begin
         sel_a = loc_a[1];
         sel_b = loc_b[1];
      end else if (eng_sel == 2'h2) begin
         sel_a = loc_a[2];
         sel_b = loc_b[2];
      end
   end

   lva_operand_mux u_op1 (
      .sel(src1_sel),
      .loc_a(sel_a),
      .loc_b(sel_b),
      .glob_c(c_ff),
      .ext_val(ext_val),
      .operand(op1_val)
   );

   lva_operand_mux u_op2 (
      .sel(src2_sel),
      .loc_a(sel_a),
      .loc_b(sel_b),
      .glob_c(c_ff),
      .ext_val(ext_val),
      .operand(op2_val)
   );

   // Operation decode, one flag per instruction kind
   logic is_load;
   logic is_add_imm;
   logic is_add_var;
   logic is_sub_imm;
   logic is_sub_var;

   // Codes 0, 6 and 7 raise no flag and so never write
   always_comb begin
      is_load = 1'b0;
      is_add_imm = 1'b0;
      is_add_var = 1'b0;
      is_sub_imm = 1'b0;
      is_sub_var = 1'b0;
      case (op_code)
         OP_LOAD_IMM: begin
            is_load = 1'b1;
         end
         OP_ADD_IMM: begin
            is_add_imm = 1'b1;
         end
         OP_ADD_VAR: begin
            is_add_var = 1'b1;
         end
         OP_SUB_IMM: begin
            is_sub_imm = 1'b1;
         end
         OP_SUB_VAR: begin
            is_sub_var = 1'b1;
         end
         default: begin
            is_load = 1'b0;
         end
      endcase
   end

   assign do_write = is_load | is_add_imm | is_add_var |
                     is_sub_imm | is_sub_var;

   // Target decode; code 3 sets none of the three
   logic tgt_is_a;
   logic tgt_is_b;
   logic tgt_is_c;

   assign tgt_is_a = (target_sel == SEL_A);
   assign tgt_is_b = (target_sel == SEL_B);
   assign tgt_is_c = (target_sel == SEL_C);

   // Engine decode; engine code 3 hits no private store
   logic [NUM_ENG-1:0] eng_hit;

   always_comb begin
      eng_hit = '0;
      if (eng_sel == ENG_W'(0)) begin
         eng_hit[0] = 1'b1;
      end else if (eng_sel == ENG_W'(1)) begin
         eng_hit[1] = 1'b1;
      end else if (eng_sel == ENG_W'(2)) begin
         eng_hit[2] = 1'b1;
      end
   end

   // Current content of the target, for the immediate forms
   always_comb begin
      tgt_val = c_ff;
      if (tgt_is_a) begin
         tgt_val = sel_a;
      end else if (tgt_is_b) begin
         tgt_val = sel_b;
      end
   end

   logic [VAR_W-1:0] imm_sum;
   logic [VAR_W-1:0] imm_diff;
   logic [VAR_W-1:0] var_sum;
   logic [VAR_W-1:0] var_diff;

   // 8-bit results drop the carry on purpose, which gives the wraparound
   assign imm_sum = VAR_W'(tgt_val + imm_val);
   assign imm_diff = VAR_W'(tgt_val - imm_val);
   assign var_sum = VAR_W'(op1_val + op2_val);
   assign var_diff = VAR_W'(op1_val - op2_val);

   // Flags are one-hot, so the order of this chain carries no priority
   always_comb begin
      nxt_result = VAR_RESET;
      if (is_load) begin
         nxt_result = imm_val;
      end else if (is_add_imm) begin
         nxt_result = imm_sum;
      end else if (is_add_var) begin
         nxt_result = var_sum;
      end else if (is_sub_imm) begin
         nxt_result = imm_diff;
      end else if (is_sub_var) begin
         nxt_result = var_diff;
      end
   end

   logic write_ok;

   assign write_ok = op_valid && do_write && eng_ok;

   // Target code 3 is outside the store and blocks every write except result_ff
   always_comb begin
      wr_a = '0;
      wr_b = '0;
      wr_c = 1'b0;
      for (int e = 0; e < NUM_ENG; e++) begin
         wr_a[e] = write_ok && eng_hit[e] && tgt_is_a;
         wr_b[e] = write_ok && eng_hit[e] && tgt_is_b;
      end
      wr_c = write_ok && tgt_is_c;
   end

   // Shared store; any engine writes, all engines read the same copy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         c_ff <= VAR_RESET;
      end else if (wr_c) begin
         c_ff <= nxt_result;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_ff <= VAR_RESET;
      end else if (op_valid && do_write) begin
         result_ff <= nxt_result;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_valid_ff <= 1'b0;
      end else begin
         result_valid_ff <= op_valid && do_write && eng_ok &&
                            (target_sel != SEL_EXT);
      end
   end

   assign var_c = c_ff;
endmodule : lva_var_alu

// ===== verification/lva_var_alu_chk.sv
// Purpose: Port checker for lva_var_alu
// Assumes: One clock, async active-low reset
// Notes: Global C is watched closely; it is the shared hazard
`timescale 1ns/10ps
module lva_var_alu_chk
   import lva_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic op_valid,
   input wire logic [lva_pkg::OP_W-1:0] op_code,
   input wire logic [lva_pkg::ENG_W-1:0] eng_sel,
   input wire logic [lva_pkg::SEL_W-1:0] target_sel,
   input wire logic [lva_pkg::SEL_W-1:0] src1_sel,
   input wire logic [lva_pkg::SEL_W-1:0] src2_sel,
   input wire logic [lva_pkg::VAR_W-1:0] imm_val,
   input wire logic [lva_pkg::VAR_W-1:0] ext_val,
   input wire logic [lva_pkg::VAR_W-1:0] result_ff,
   input wire logic result_valid_ff,
   input wire logic [lva_pkg::VAR_W-1:0] op1_val,
   input wire logic [lva_pkg::VAR_W-1:0] op2_val,
   input wire logic [lva_pkg::VAR_W*lva_pkg::NUM_ENG-1:0] var_a_all,
   input wire logic [lva_pkg::VAR_W*lva_pkg::NUM_ENG-1:0] var_b_all,
   input wire logic [lva_pkg::VAR_W-1:0] var_c
);
   logic tk;
   logic tc;
   assign tk = op_valid && op_code inside {[OP_LOAD_IMM:OP_SUB_VAR]}
      && eng_sel != 2'h3 && target_sel != SEL_EXT;
   assign tc = tk && target_sel == SEL_C;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   pulse_on_write_a: assert property (tk |=> result_valid_ff)
      else $error("valid pulse missing");
   no_stray_pulse_a: assert property (!tk |=> !result_valid_ff)
      else $error("valid pulse without write");
   c_load_a: assert property (tc && op_code == OP_LOAD_IMM |=>
      var_c == $past(imm_val)) else $error("load of C wrong");
   c_add_imm_a: assert property (tc && op_code == OP_ADD_IMM |=>
      var_c == $past(var_c) + $past(imm_val)) else $error("C add imm");
   c_sub_imm_a: assert property (tc && op_code == OP_SUB_IMM |=>
      var_c == $past(var_c) - $past(imm_val)) else $error("C sub imm");
   c_add_var_a: assert property (tc && op_code == OP_ADD_VAR |=>
      var_c == $past(op1_val) + $past(op2_val)) else $error("C add var");
   c_sub_var_a: assert property (tc && op_code == OP_SUB_VAR |=>
      var_c == $past(op1_val) - $past(op2_val)) else $error("C sub var");
   c_hold_a: assert property (!tc |=> $stable(var_c))
      else $error("C changed without write");
   local_hold_a: assert property (!tk |=> $stable(var_a_all) &&
      $stable(var_b_all)) else $error("local changed without write");
   ext_select_a: assert property (src2_sel == SEL_EXT |->
      op2_val == ext_val) else $error("external operand wrong");
endmodule : lva_var_alu_chk
bind lva_var_alu lva_var_alu_chk u_chk (.*);

// ===== verification/lva_seq_model.sv
// Purpose: Sequencer stand-in driving the datapath fields
// Assumes: Fields change at the falling clock edge
// Notes: Fields are inverted when idle, never left stale
`timescale 1ns/10ps
module lva_seq_model
   import lva_pkg::*;
(
   input wire logic clk,
   output logic op_valid,
   output logic [lva_pkg::OP_W-1:0] op_code,
   output logic [lva_pkg::ENG_W-1:0] eng_sel,
   output logic [lva_pkg::SEL_W-1:0] target_sel,
   output logic [lva_pkg::SEL_W-1:0] src1_sel,
   output logic [lva_pkg::SEL_W-1:0] src2_sel,
   output logic [lva_pkg::VAR_W-1:0] imm_val,
   output logic [lva_pkg::VAR_W-1:0] ext_val
);
   logic [18:0] lf = '0;
   initial begin
      op_valid = 1'b0;
      {op_code, eng_sel, target_sel, src1_sel, src2_sel, imm_val} = '0;
      ext_val = 8'h3c;
   end
   // Target code 3 goes out when a test asks for it, or on idle after a target A operation
   task issue(input logic [18:0] f);
      @(negedge clk);
      lf = f;
      op_valid = 1'b1;
      {op_code, eng_sel, target_sel, src1_sel, src2_sel, imm_val} = f;
   endtask : issue
   task idle();
      @(negedge clk);
      op_valid = 1'b0;
      {op_code, eng_sel, target_sel, src1_sel, src2_sel, imm_val} = ~lf;
   endtask : idle
endmodule : lva_seq_model

// ===== verification/lva_var_alu_tb.sv
// Purpose: Self-checking bench for lva_var_alu
// Assumes: Sequencer model drives every operation field
// Notes: Shadow copies of A, B and C give the expected values
`timescale 1ns/10ps
module lva_var_alu_tb;
   import lva_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic v, rv;
   logic [2:0] oc;
   logic [1:0] es, ts, s1, s2;
   logic [7:0] im, ex, res, o1, o2, vc, ec, lr;
   logic [23:0] va, vb;
   logic [7:0] ea [3];
   logic [7:0] eb [3];
   int failures = 0;
   int cmp_count = 0;
   always #12.5 clk = ~clk;
   lva_seq_model u_seq (.clk(clk), .op_valid(v), .op_code(oc), .eng_sel(es),
      .target_sel(ts), .src1_sel(s1), .src2_sel(s2), .imm_val(im),
      .ext_val(ex));
   lva_var_alu u_dut (.clk(clk), .rstn(rstn), .op_valid(v), .op_code(oc),
      .eng_sel(es), .target_sel(ts), .src1_sel(s1), .src2_sel(s2),
      .imm_val(im), .ext_val(ex), .result_ff(res), .result_valid_ff(rv),
      .op1_val(o1), .op2_val(o2), .var_a_all(va), .var_b_all(vb),
      .var_c(vc));
   function automatic logic [7:0] pick(int g, logic [1:0] s);
      return s == SEL_A ? ea[g] : s == SEL_B ? eb[g] : s == SEL_C ? ec : ex;
   endfunction : pick
   task cmp(logic [7:0] g, logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task op(logic [2:0] o, int g, logic [1:0] t, logic [1:0] a,
      logic [1:0] b, logic [7:0] k);
      logic [7:0] r;
      r = o == OP_LOAD_IMM ? k : o == OP_ADD_IMM ? pick(g, t) + k :
         o == OP_SUB_IMM ? pick(g, t) - k : o == OP_ADD_VAR ?
         pick(g, a) + pick(g, b) : pick(g, a) - pick(g, b);
      u_seq.issue({o, 2'(g), t, a, b, k});
      if (g < 3 && t != SEL_EXT && o inside {[1:5]}) begin
         lr = r;
         if (t == SEL_A) ea[g] = r;
         else if (t == SEL_B) eb[g] = r;
         else ec = r;
      end
   endtask : op
   // Compares every variable after the last operation has landed
   task chk();
      u_seq.idle();
      for (int g = 0; g < 3; g++) begin
         cmp(va[8*g+:8], ea[g]);
         cmp(vb[8*g+:8], eb[g]);
      end
      cmp(vc, ec);
   endtask : chk
   task t_local();
      for (int g = 0; g < 3; g++) begin
         op(OP_LOAD_IMM, g, SEL_A, 0, 0, 8'h10 + g);
         op(OP_LOAD_IMM, g, SEL_B, 0, 0, 8'hf0 - g);
      end
      op(OP_LOAD_IMM, 2, SEL_C, 0, 0, 8'h5a);
      chk();
      cmp({7'h0, rv}, 8'h01);
   endtask : t_local
   task t_wrap();
      op(OP_LOAD_IMM, 0, SEL_A, 0, 0, 8'hff);
      op(OP_ADD_IMM, 0, SEL_A, 0, 0, 8'h01);
      op(OP_SUB_IMM, 0, SEL_C, 0, 0, 8'h5b);
      op(OP_ADD_IMM, 0, SEL_C, 0, 0, 8'h03);
      op(OP_ADD_VAR, 1, SEL_C, SEL_B, SEL_B, 0);
      op(OP_SUB_VAR, 1, SEL_C, SEL_A, SEL_B, 0);
      chk();
      cmp(res, lr);
   endtask : t_wrap
   task t_src();
      logic [7:0] p1;
      logic [7:0] p2;
      for (int a = 0; a < 4; a++) begin
         for (int b = 0; b < 4; b++) begin
            p1 = pick(1, a[1:0]);
            p2 = pick(1, b[1:0]);
            op(a[0] ? OP_ADD_VAR : OP_SUB_VAR, 1, SEL_B, a, b, 0);
            #1;
            cmp(o1, p1);
            cmp(o2, p2);
         end
      end
      op(OP_ADD_VAR, 0, SEL_A, SEL_C, SEL_A, 0);
      chk();
   endtask : t_src
   // Rejected requests must leave every variable alone
   task t_refuse();
      op(OP_LOAD_IMM, 0, SEL_EXT, 0, 0, 8'h77);
      op(OP_LOAD_IMM, 3, SEL_A, 0, 0, 8'h77);
      for (int o = 6; o < 9; o++) begin
         op(o[2:0], 0, SEL_C, 0, 0, 8'h77);
      end
      chk();
      cmp({7'h0, rv}, 8'h00);
   endtask : t_refuse
   task results();
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      ea = '{3{8'h00}};
      eb = '{3{8'h00}};
      ec = 8'h00;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      chk();
      t_local();
      t_wrap();
      t_src();
      t_refuse();
      results();
   end
   // Thirty-five operations are run; far fewer cycles than this
   initial begin
      #(25 * 2000);
      failures++;
      results();
   end
endmodule : lva_var_alu_tb
